// >>> bld_pkg.sv
package bld_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REG = 6;

  // register offsets
  localparam logic [7:0] ADDR_BOOST_CONTROL  = 8'h66;
  localparam logic [7:0] ADDR_REG_CTL_BASE   = 8'h70;
  localparam logic [7:0] ADDR_FAULT_FLAGS    = 8'h76;
  localparam logic [7:0] ADDR_FAULT_MASK     = 8'h77;
  localparam logic [7:0] ADDR_PROTECT_CTL    = 8'h78;

  // boost_control fields
  localparam int unsigned BST_LEVEL_LSB = 0;
  localparam int unsigned BST_RUN_LSB   = 2;
  localparam int unsigned BST_IDLE_LSB  = 5;
  localparam logic [1:0]  BST_LEVEL_RST = 2'h0;
  localparam logic [1:0]  BST_RUN_RST   = 2'h2;
  localparam logic [1:0]  BST_IDLE_RST  = 2'h2;

  // boost switching mode codes
  typedef enum logic [1:0] {
    BLD_SW_OFF  = 2'h0,
    BLD_SW_PFM  = 2'h1,
    BLD_SW_AUTO = 2'h2,
    BLD_SW_SKIP = 2'h3
  } bld_sw_mode_t;

  // regulator output state codes
  typedef enum logic [1:0] {
    BLD_OUT_OFF = 2'h0,
    BLD_OUT_ON  = 2'h1,
    BLD_OUT_LP  = 2'h2
  } bld_out_t;

  // regulator_control_reg layout, bit 7 reads zero
  typedef struct packed {
    logic       pad;
    logic       on_bit;
    logic       low_power;
    logic       idle_off;
    logic [3:0] level;
  } bld_ctl_t;

  localparam bld_ctl_t CTL_RST = '{pad: 1'b0, on_bit: 1'b0, low_power: 1'b0,
                                   idle_off: 1'b0, level: 4'h0};

  // regulator indices
  localparam int unsigned IDX_ONE   = 0;
  localparam int unsigned IDX_TWO   = 1;
  localparam int unsigned IDX_THREE = 2;
  localparam int unsigned IDX_FOUR  = 3;
  localparam int unsigned IDX_IO    = 4;
  localparam int unsigned IDX_CARD  = 5;

  // level decode in millivolts
  localparam logic [12:0] BST_BASE_MV  = 13'h1388;
  localparam logic [12:0] BST_STEP_MV  = 13'h0032;
  localparam logic [11:0] HI_BASE_MV   = 12'h708;
  localparam logic [11:0] HI_STEP_MV   = 12'h064;
  localparam logic [11:0] LO_BASE_MV   = 12'h320;
  localparam logic [11:0] LO_STEP_MV   = 12'h032;
  localparam logic [11:0] IO_BASE_MV   = 12'hb22;
  localparam logic [11:0] IO_STEP_MV   = 12'h096;
  localparam logic [11:0] CARD_LOW_MV  = 12'h708;
  localparam logic [11:0] CARD_TOP_MV  = 12'h73a;
  localparam logic [1:0]  CARD_TOP_CODE = 2'h3;

  // overload shutdown time
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned OVL_TIME_US    = 8000;
  localparam int unsigned OVL_CYCLES     = OVL_TIME_US * CLK_MHZ;

endpackage

// >>> bld_core.sv
`timescale 1ns/1ps
//Contract
// - boost joins power-up sequence only if its fused sequence slot is nonzero
// - boost level bits 1:0, reset 00, decode 5.000 to 5.150 V, read/write
// - run mode bits 3:2 read-only, reset 10 automatic
// - idle mode bits 6:5 writable, reset 10, used during standby
// - automatic mode picks pulse-freq or pulse-skip by load; starts automatic
// - a disabled regulator connects its output pull-down
// - with shutdown enabled, limit over 8.0 ms clears that regulator's on bit
// - per-regulator fault flag, mask bit keeps it off the interrupt
// - overload shutdown enable resets cleared
// - fault flag raised on overload whatever the shutdown enable
// - power-up copies fused levels into each regulator control register
// - regulators one/two decode four-bit codes, 1.80-3.30 V and 0.80-1.55 V
// - regulators three/four decode 1.80 to 3.30 V in 0.1 V steps
// - io rail decodes 2.85, 3.00, 3.15, 3.30 V
// - card rail decodes 2.85-3.30 V, or 1.80/1.85 V with select high
// - host may enable, disable and set idle behaviour of each regulator anytime
// - on bit 0 gives off; on with idle bit 0: low-power bit picks on/low-power
// - on and idle bits set: on outside standby, else off or low-power
module bld_core
  import bld_pkg::*;
#(
  parameter int unsigned OVL_LIMIT = bld_pkg::OVL_CYCLES
) (
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_b_i,
  // register port
  input  wire logic [bld_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [bld_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [bld_pkg::DATA_W-1:0] reg_rdata_o,
  // fuse contents and power-up sequencer
  input  wire logic [2:0]                step_up_sequence_slot_i,
  input  wire logic [5:0][3:0]           fused_regulator_levels_i,
  input  wire logic                      fuse_load_i,
  input  wire logic                      step_up_seq_on_i,
  // analog and pin inputs
  input  wire logic                      standby_i,
  input  wire logic [5:0]                current_limit_i,
  input  wire logic                      card_rail_select_i,
  input  wire logic                      step_up_heavy_load_i,
  // boost outputs
  output logic                           step_up_in_sequence_o,
  output logic      [12:0]               step_up_level_mv_o,
  output bld_sw_mode_t                   step_up_switching_o,
  // regulator outputs
  output bld_out_t  [5:0]                regulator_state_o,
  output logic      [5:0]                regulator_pulldown_o,
  output logic      [5:0][11:0]          regulator_level_mv_o,
  output logic                           fault_irq_o
);
  import bld_pkg::*;

  localparam int unsigned CNT_W = $clog2(OVL_LIMIT + 2);

  function automatic logic [11:0] level_mv(input int unsigned idx, input logic [3:0] code,
                                           input logic sel);
    logic [11:0] mv;
    mv = HI_BASE_MV + 12'(code) * HI_STEP_MV;
    if (idx == IDX_TWO) begin
      mv = LO_BASE_MV + 12'(code) * LO_STEP_MV;
    end else if (idx == IDX_IO || (idx == IDX_CARD && !sel)) begin
      mv = IO_BASE_MV + 12'(code[1:0]) * IO_STEP_MV;
    end else if (idx == IDX_CARD) begin
      mv = (code[1:0] == CARD_TOP_CODE) ? CARD_TOP_MV : CARD_LOW_MV;
    end
    return mv;
  endfunction

  // control registers sit at consecutive offsets, one per regulator
  function automatic logic ctl_hit(input logic [bld_pkg::ADDR_W-1:0] addr,
                                   input int unsigned idx);
    return addr == ADDR_REG_CTL_BASE + 8'(idx);
  endfunction

  // two-flop synchronisers for pin and analog inputs
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {step_up_heavy_load_i, card_rail_select_i, standby_i, current_limit_i};
      sync2_r <= sync1_r;
    end
  end

  logic [5:0] limit_s;
  logic       standby_s;
  logic       card_sel_s;
  logic       heavy_s;
  assign limit_s    = sync2_r[5:0];
  assign standby_s  = sync2_r[6];
  assign card_sel_s = sync2_r[7];
  assign heavy_s    = sync2_r[8];

  // write decode
  logic       wr_boost;
  logic       wr_flags;
  logic       wr_mask;
  logic       wr_protect;
  logic [5:0] wr_ctl;
  always_comb begin
    wr_boost   = reg_wr_i && reg_addr_i == ADDR_BOOST_CONTROL;
    wr_flags   = reg_wr_i && reg_addr_i == ADDR_FAULT_FLAGS;
    wr_mask    = reg_wr_i && reg_addr_i == ADDR_FAULT_MASK;
    wr_protect = reg_wr_i && reg_addr_i == ADDR_PROTECT_CTL;
    for (int i = 0; i < NUM_REG; i++) begin
      wr_ctl[i] = reg_wr_i && ctl_hit(reg_addr_i, i);
    end
  end

  // boost control register
  logic [1:0]   bst_level_r;
  bld_sw_mode_t bst_idle_r;
  bld_sw_mode_t bst_run;
  assign bst_run = BLD_SW_AUTO;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bst_level_r <= BST_LEVEL_RST;
      bst_idle_r  <= bld_sw_mode_t'(BST_IDLE_RST);
    end else if (wr_boost) begin
      bst_level_r <= reg_wdata_i[BST_LEVEL_LSB +: 2];
      bst_idle_r  <= bld_sw_mode_t'(reg_wdata_i[BST_IDLE_LSB +: 2]);
    end
  end

  // boost sequencing and switching mode
  logic         in_seq;
  bld_sw_mode_t sel_mode;
  assign in_seq = step_up_sequence_slot_i != 3'h0;
  always_comb begin
    sel_mode = standby_s ? bst_idle_r : bst_run;
    if (sel_mode == BLD_SW_AUTO) begin
      sel_mode = heavy_s ? BLD_SW_SKIP : BLD_SW_PFM;
    end
    if (!(in_seq && step_up_seq_on_i)) begin
      sel_mode = BLD_SW_OFF;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_up_in_sequence_o <= 1'b0;
      step_up_level_mv_o    <= BST_BASE_MV;
      step_up_switching_o   <= BLD_SW_OFF;
    end else begin
      step_up_in_sequence_o <= in_seq;
      step_up_level_mv_o    <= BST_BASE_MV + 13'(bst_level_r) * BST_STEP_MV;
      step_up_switching_o   <= sel_mode;
    end
  end

  // current-limit timers, one per regulator
  logic [5:0][CNT_W-1:0] ovl_cnt_r;
  logic [5:0]            expire;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovl_cnt_r <= '0;
    end else begin
      for (int i = 0; i < NUM_REG; i++) begin
        if (!limit_s[i]) begin
          ovl_cnt_r[i] <= '0;
        end else if (ovl_cnt_r[i] <= CNT_W'(OVL_LIMIT)) begin
          ovl_cnt_r[i] <= ovl_cnt_r[i] + 1'b1;
        end
      end
    end
  end
  // one pulse per overload episode, once the limit has lasted past the window
  always_comb begin
    for (int i = 0; i < NUM_REG; i++) begin
      expire[i] = limit_s[i] && ovl_cnt_r[i] == CNT_W'(OVL_LIMIT);
    end
  end

  // protection enable, fault flags and masks
  logic       shut_en_r;
  logic [5:0] flag_r;
  logic [5:0] mask_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shut_en_r <= 1'b0;
    end else if (wr_protect) begin
      shut_en_r <= reg_wdata_i[0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_r <= '0;
    end else begin
      // a new fault wins over a clear in the same cycle
      flag_r <= (flag_r & ~(wr_flags ? reg_wdata_i[5:0] : 6'h00)) | expire;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= reg_wdata_i[5:0];
    end
  end

  assign fault_irq_o = |(flag_r & ~mask_r);

  // regulator control registers
  bld_ctl_t [5:0] ctl_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_r <= {NUM_REG{CTL_RST}};
    end else begin
      for (int i = 0; i < NUM_REG; i++) begin
        if (wr_ctl[i]) begin
          ctl_r[i]     <= bld_ctl_t'(reg_wdata_i);
          ctl_r[i].pad <= 1'b0;
        end
        if (fuse_load_i) begin
          ctl_r[i].level <= fused_regulator_levels_i[i];
        end
        // shutdown beats a host write landing in the same cycle
        if (expire[i] && shut_en_r) begin
          ctl_r[i].on_bit <= 1'b0;
        end
      end
    end
  end

  // output truth table and level decode
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regulator_state_o    <= '{default: BLD_OUT_OFF};
      regulator_pulldown_o <= '1;
      regulator_level_mv_o <= '0;
    end else begin
      for (int i = 0; i < NUM_REG; i++) begin
        if (!ctl_r[i].on_bit) begin
          regulator_state_o[i] <= BLD_OUT_OFF;
        end else if (ctl_r[i].idle_off && !standby_s) begin
          regulator_state_o[i] <= BLD_OUT_ON;
        end else if (ctl_r[i].low_power) begin
          regulator_state_o[i] <= BLD_OUT_LP;
        end else begin
          regulator_state_o[i] <= ctl_r[i].idle_off ? BLD_OUT_OFF : BLD_OUT_ON;
        end
        regulator_pulldown_o[i] <= !ctl_r[i].on_bit ||
                                   (ctl_r[i].idle_off && standby_s && !ctl_r[i].low_power);
        regulator_level_mv_o[i] <= level_mv(i, ctl_r[i].level, card_sel_s);
      end
    end
  end

  // read port, registered; unmapped addresses read zero
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      if (reg_addr_i == ADDR_BOOST_CONTROL) begin
        reg_rdata_o <= {1'b0, bst_idle_r, 1'b0, bst_run, bst_level_r};
      end else if (reg_addr_i == ADDR_FAULT_FLAGS) begin
        reg_rdata_o <= {2'h0, flag_r};
      end else if (reg_addr_i == ADDR_FAULT_MASK) begin
        reg_rdata_o <= {2'h0, mask_r};
      end else if (reg_addr_i == ADDR_PROTECT_CTL) begin
        reg_rdata_o <= {7'h00, shut_en_r};
      end
      for (int i = 0; i < NUM_REG; i++) begin
        if (ctl_hit(reg_addr_i, i)) begin
          reg_rdata_o <= ctl_r[i];
        end
      end
    end
  end

endmodule // bld_core

// >>> bld_core_properties.sv
`timescale 1ns/1ps
module bld_core_properties
  import bld_pkg::*;
#(
  parameter int unsigned OVL_LIMIT = 20
) (
  input wire logic                        clock_i,
  input wire logic                        rst_b_i,
  input wire logic [bld_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic                        reg_rd_i,
  input wire logic [bld_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [2:0]                  step_up_sequence_slot_i,
  input wire logic                        step_up_in_sequence_o,
  input wire logic [12:0]                 step_up_level_mv_o,
  input wire bld_sw_mode_t                step_up_switching_o,
  input wire bld_out_t [5:0]              regulator_state_o,
  input wire logic [5:0]                  regulator_pulldown_o,
  input wire logic [5:0][11:0]            regulator_level_mv_o
);
  logic [5:0] off_w;
  logic [5:0] bad_w;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      off_w[i] = (regulator_state_o[i] == BLD_OUT_OFF);
      bad_w[i] = (regulator_state_o[i] == 2'h3);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence rd_boost_s;
    reg_rd_i && (reg_addr_i == ADDR_BOOST_CONTROL);
  endsequence
  // decoded levels are not valid until one edge after reset
  sequence run_s;
    $past(rst_b_i);
  endsequence
  seq_slot_a: assert property (run_s |-> step_up_in_sequence_o == (|$past(step_up_sequence_slot_i))) else $error("sequence flag wrong");
  pull_down_a: assert property (regulator_pulldown_o == off_w) else $error("pull-down wrong");
  state_code_a: assert property (bad_w == 6'h00) else $error("bad state code");
  boost_level_a: assert property (step_up_level_mv_o inside {13'h1388, 13'h13ba, 13'h13ec, 13'h141e}) else $error("boost level");
  mode_resolved_a: assert property (step_up_switching_o != BLD_SW_AUTO) else $error("auto unresolved");
  boost_ro_a: assert property (rd_boost_s |=> reg_rdata_o[4:2] == 3'h2 && !reg_rdata_o[7]) else $error("boost read-only bits");
  one_level_a: assert property (run_s |-> (regulator_level_mv_o[0] - 12'h708) % 12'h064 == 12'h000 && regulator_level_mv_o[0] inside {[12'h708:12'hce4]}) else $error("level one");
  io_level_a: assert property (run_s |-> regulator_level_mv_o[4] inside {12'hb22, 12'hbb8, 12'hc4e, 12'hce4}) else $error("io level");
  card_level_a: assert property (run_s |-> regulator_level_mv_o[5] inside {12'hb22, 12'hbb8, 12'hc4e, 12'hce4, 12'h708, 12'h73a}) else $error("card level");
endmodule // bld_core_properties

bind bld_core bld_core_properties #(.OVL_LIMIT(OVL_LIMIT)) bld_core_properties_i (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .step_up_sequence_slot_i(step_up_sequence_slot_i),
  .step_up_in_sequence_o(step_up_in_sequence_o), .step_up_level_mv_o(step_up_level_mv_o),
  .step_up_switching_o(step_up_switching_o), .regulator_state_o(regulator_state_o),
  .regulator_pulldown_o(regulator_pulldown_o), .regulator_level_mv_o(regulator_level_mv_o));

// >>> bld_host_model.sv
`timescale 1ns/1ps
module bld_host_model
  import bld_pkg::*;
(
  // clock
  input  wire logic                        clock_i,
  // register port
  output logic      [bld_pkg::ADDR_W-1:0] reg_addr_o,
  output logic      [bld_pkg::DATA_W-1:0] reg_wdata_o,
  output logic                             reg_wr_o,
  output logic                             reg_rd_o,
  input  wire logic [bld_pkg::DATA_W-1:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // released lines show the inverse so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_wr_o <= 1'b1;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clock_i);
    #1 v = reg_rdata_i;
  endtask
endmodule // bld_host_model

// >>> tb_bld_core.sv
`timescale 1ns/1ps
module tb_bld_core;
  import bld_pkg::*;
  localparam int unsigned LIM = 20;
  logic            clock_i = 1'b0;
  logic            rst_b_i = 1'b0;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic            wr;
  logic            rd;
  logic [2:0]      slot = 3'h0;
  logic [5:0][3:0] fused = '0;
  logic            fload = 1'b0;
  logic            seq_on = 1'b0;
  logic            stby = 1'b0;
  logic            csel = 1'b0;
  logic            heavy = 1'b0;
  logic [5:0]      climit = 6'h00;
  logic            in_seq;
  logic [12:0]     bmv;
  bld_sw_mode_t    sw;
  bld_out_t [5:0]  st;
  logic [5:0]      pd;
  logic [5:0][11:0] lmv;
  logic            irq;
  logic [7:0]      d;
  int              errors = 0;
  int              checks_done = 0;
  int              cyc = 0;
  always #5 clock_i = ~clock_i;
  bld_core #(.OVL_LIMIT(LIM)) bld_core_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .step_up_sequence_slot_i(slot), .fused_regulator_levels_i(fused), .fuse_load_i(fload),
    .step_up_seq_on_i(seq_on), .standby_i(stby), .current_limit_i(climit),
    .card_rail_select_i(csel), .step_up_heavy_load_i(heavy), .step_up_in_sequence_o(in_seq),
    .step_up_level_mv_o(bmv), .step_up_switching_o(sw), .regulator_state_o(st),
    .regulator_pulldown_o(pd), .regulator_level_mv_o(lmv), .fault_irq_o(irq));
  bld_host_model bld_host_model_i (.clock_i(clock_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bld_host_model_i.rd(a, d);
    chk("rdata", {8'h00, e}, {8'h00, d});
  endtask
  task automatic t_reset;
    rdc(ADDR_BOOST_CONTROL, 8'h48);
    rdc(ADDR_PROTECT_CTL, 8'h00);
    rdc(8'h80, 8'h00);
    chk("pulldown", 16'h003f, {10'h000, pd});
    chk("boost_mv", 16'h1388, {3'h0, bmv});
    $display("test reset done");
  endtask
  task automatic t_boost;
    bld_host_model_i.wr(ADDR_BOOST_CONTROL, 8'hff);
    rdc(ADDR_BOOST_CONTROL, 8'h6b);
    for (int c = 0; c < 4; c++) begin
      bld_host_model_i.wr(ADDR_BOOST_CONTROL, 8'(c));
      cy(3);
      chk("boost_mv", 16'h1388 + 16'(c) * 16'h0032, {3'h0, bmv});
    end
    seq_on <= 1'b1;
    heavy <= 1'b1;
    cy(6);
    chk("in_seq", 16'h0000, {15'h0000, in_seq});
    chk("mode", 16'h0000, {14'h0000, sw});
    slot <= 3'h4;
    cy(6);
    chk("in_seq", 16'h0001, {15'h0000, in_seq});
    chk("mode", 16'h0003, {14'h0000, sw});
    heavy <= 1'b0;
    cy(6);
    chk("mode", 16'h0001, {14'h0000, sw});
    stby <= 1'b1;
    cy(6);
    chk("mode", 16'h0000, {14'h0000, sw});
    bld_host_model_i.wr(ADDR_BOOST_CONTROL, 8'h20);
    cy(3);
    chk("mode", 16'h0001, {14'h0000, sw});
    bld_host_model_i.wr(ADDR_BOOST_CONTROL, 8'h40);
    heavy <= 1'b1;
    cy(6);
    chk("mode", 16'h0003, {14'h0000, sw});
    stby <= 1'b0;
    $display("test boost done");
  endtask
  task automatic t_levels;
    logic [15:0] m;
    for (int c = 0; c < 16; c++) begin
      for (int r = 0; r < 6; r++) bld_host_model_i.wr(ADDR_REG_CTL_BASE + 8'(r), 8'h40 | 8'(c));
      csel <= c[3];
      cy(6);
      m = 16'(c % 4) * 16'h0096;
      chk("one_mv", 16'h0708 + 16'(c) * 16'h0064, {4'h0, lmv[0]});
      chk("two_mv", 16'h0320 + 16'(c) * 16'h0032, {4'h0, lmv[1]});
      chk("three_mv", 16'h0708 + 16'(c) * 16'h0064, {4'h0, lmv[2]});
      chk("four_mv", 16'h0708 + 16'(c) * 16'h0064, {4'h0, lmv[3]});
      chk("io_mv", 16'h0b22 + m, {4'h0, lmv[4]});
      chk("card_mv", c[3] ? (c % 4 == 3 ? 16'h073a : 16'h0708) : 16'h0b22 + m, {4'h0, lmv[5]});
    end
    $display("test levels done");
  endtask
  task automatic t_table;
    bld_out_t e;
    for (int v = 0; v < 16; v++) begin
      bld_host_model_i.wr(ADDR_REG_CTL_BASE, {1'b0, v[3], v[2], v[1], 4'h0});
      stby <= v[0];
      cy(6);
      e = !v[3] ? BLD_OUT_OFF : !v[1] ? (v[2] ? BLD_OUT_LP : BLD_OUT_ON) :
          !v[0] ? BLD_OUT_ON : (v[2] ? BLD_OUT_LP : BLD_OUT_OFF);
      chk("state", {14'h0000, e}, {14'h0000, st[0]});
      chk("pulldown", {15'h0000, e == BLD_OUT_OFF}, {15'h0000, pd[0]});
    end
    stby <= 1'b0;
    $display("test table done");
  endtask
  task automatic t_fuse;
    for (int r = 0; r < 6; r++) fused[r] <= 4'(r + 9);
    fload <= 1'b1;
    cy(1);
    fload <= 1'b0;
    cy(3);
    for (int r = 0; r < 6; r++) begin
      bld_host_model_i.rd(ADDR_REG_CTL_BASE + 8'(r), d);
      chk("fused", 16'((r + 9) & (r < 4 ? 15 : 3)), 16'(d[3:0] & (r < 4 ? 4'hf : 4'h3)));
    end
    $display("test fuse done");
  endtask
  task automatic ovl(input int n);
    climit[0] <= 1'b1;
    cy(n);
    climit[0] <= 1'b0;
    cy(6);
  endtask
  task automatic t_ovl;
    bld_host_model_i.wr(ADDR_REG_CTL_BASE, 8'h40);
    ovl(LIM + 10);
    rdc(ADDR_FAULT_FLAGS, 8'h01);
    chk("irq", 16'h0001, {15'h0000, irq});
    rdc(ADDR_REG_CTL_BASE, 8'h40);
    bld_host_model_i.wr(ADDR_FAULT_FLAGS, 8'h01);
    rdc(ADDR_FAULT_FLAGS, 8'h00);
    ovl(LIM - 8);
    ovl(LIM - 8);
    rdc(ADDR_FAULT_FLAGS, 8'h00);
    bld_host_model_i.wr(ADDR_FAULT_MASK, 8'h01);
    ovl(LIM + 10);
    chk("irq", 16'h0000, {15'h0000, irq});
    rdc(ADDR_FAULT_FLAGS, 8'h01);
    bld_host_model_i.wr(ADDR_FAULT_FLAGS, 8'h01);
    bld_host_model_i.wr(ADDR_FAULT_MASK, 8'h00);
    bld_host_model_i.wr(ADDR_PROTECT_CTL, 8'h01);
    ovl(LIM + 10);
    rdc(ADDR_REG_CTL_BASE, 8'h00);
    chk("state", 16'h0000, {14'h0000, st[0]});
    $display("test overload done");
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    cy(16);
    rst_b_i <= 1'b1;
    cy(2);
    t_reset();
    t_boost();
    t_levels();
    t_table();
    t_fuse();
    t_ovl();
    end_sim();
  end
endmodule // tb_bld_core
